// File: host_interrupt_status_enable.sv
// interrupt status, clear and enable registers on an axi4-lite slave
module host_interrupt_status_enable
  import irq_regs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DEC_W-1:0]  decoder_event_set,
  input  wire logic [SUBT_W-1:0] subcode_timer_set,
  input  wire logic              command_done,
  input  wire logic              command_rejected,
  input  wire logic              bus_reset_line_n,
  input  wire logic              attention_line_n,
  input  wire logic              target_mode,
  input  wire logic              bus_parity_error,
  input  wire logic              selected_with_attention,
  input  wire logic              selected_no_attention,
  input  wire logic              reselect_start,
  input  wire logic              reselect_attempt_failed,
  input  wire logic              scam_init_failed,
  input  wire logic              scam_selected,
  output logic                   parity_check_enable,
  output logic                   irq
);
  logic              aw_held_r;
  logic              w_held_r;
  logic [IDX_W-1:0]  aw_idx_r;
  logic [7:0]        wdata_r;
  logic              wlane_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic              wr_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        rd_value;
  logic [IDX_W-1:0]  ar_idx;

  logic [DEC_W-1:0]  dec_enable_r;
  logic [SUBT_W-1:0] subt_enable_r;
  logic [SCSI_W-1:0] scsi_enable_r;
  logic [SCAM_W-1:0] scam_enable_r;
  logic [7:0]        config_r;

  logic [DEC_W-1:0]  dec_clear;
  logic [SUBT_W-1:0] subt_clear;
  logic [SCSI_W-1:0] scsi_clear;
  logic [SCAM_W-1:0] scam_clear;
  logic [DEC_W-1:0]  dec_status;
  logic [SUBT_W-1:0] subt_status;
  logic [SCSI_W-1:0] scsi_status;
  logic [SCAM_W-1:0] scam_status;
  logic              dec_active;
  logic              subt_active;
  logic              scsi_active;
  logic              scam_active;
  logic [SCSI_W-1:0] scsi_set;
  logic [SCAM_W-1:0] scam_set;

  logic [1:0]        rst_sync_r;
  logic [1:0]        atn_sync_r;
  logic              rst_prev_r;
  logic              atn_prev_r;
  logic              rst_edge;
  logic              atn_edge;
  logic [RETRY_W-1:0] retry_cnt_r;
  logic [RETRY_W-1:0] retry_limit;
  logic              resel_fail_set;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      aw_idx_r  <= s_axi_awaddr[IDX_LSB +: IDX_W];
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wlane_r  <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata[7:0];
      wlane_r  <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_comb
  begin
    if (aw_idx_r == IDX_DECODER_STATUS || aw_idx_r == IDX_SUBCODE_TIMER)
      wr_hit = 1'b1;
    else if (aw_idx_r == IDX_SCSI_EVENT || aw_idx_r == IDX_SCAM_EVENT)
      wr_hit = 1'b1;
    else if (aw_idx_r == IDX_DECODER_ENABLE || aw_idx_r == IDX_SUBTIM_ENABLE)
      wr_hit = 1'b1;
    else if (aw_idx_r == IDX_SCSI_ENABLE || aw_idx_r == IDX_SCAM_ENABLE)
      wr_hit = 1'b1;
    else if (aw_idx_r == IDX_SCSI_CONFIG)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // clear strobes live for the single commit cycle only
  always_comb
  begin
    dec_clear  = '0;
    subt_clear = '0;
    scsi_clear = '0;
    scam_clear = '0;
    if (wr_fire && wlane_r)
    begin
      if (aw_idx_r == IDX_DECODER_STATUS)
        dec_clear = wdata_r & DEC_MASK;
      else if (aw_idx_r == IDX_SUBCODE_TIMER)
        subt_clear = wdata_r[SUBT_W-1:0];
      else if (aw_idx_r == IDX_SCSI_EVENT)
        scsi_clear = wdata_r;
      else if (aw_idx_r == IDX_SCAM_EVENT)
        scam_clear = wdata_r[SCAM_W-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dec_enable_r  <= ENABLE_RESET[DEC_W-1:0];
      subt_enable_r <= ENABLE_RESET[SUBT_W-1:0];
      scsi_enable_r <= ENABLE_RESET[SCSI_W-1:0];
      scam_enable_r <= ENABLE_RESET[SCAM_W-1:0];
      config_r      <= CONFIG_RESET;
    end
    else if (wr_fire && wlane_r)
    begin
      if (aw_idx_r == IDX_DECODER_ENABLE)
        dec_enable_r <= wdata_r & DEC_MASK;
      else if (aw_idx_r == IDX_SUBTIM_ENABLE)
        subt_enable_r <= wdata_r[SUBT_W-1:0] & SUBT_MASK;
      else if (aw_idx_r == IDX_SCSI_ENABLE)
        scsi_enable_r <= wdata_r;
      else if (aw_idx_r == IDX_SCAM_ENABLE)
        scam_enable_r <= wdata_r[SCAM_W-1:0];
      else if (aw_idx_r == IDX_SCSI_CONFIG)
        config_r <= wdata_r;
    end
  end

  assign parity_check_enable = config_r[BIT_PARITY_ENABLE];
  assign retry_limit         = config_r[RETRY_LSB +: RETRY_W];

  // read channel: one register stage, answer after one edge
  assign s_axi_arready = !rvalid_r;
  assign ar_idx        = s_axi_araddr[IDX_LSB +: IDX_W];

  always_comb
  begin
    rd_hit   = 1'b1;
    rd_value = '0;
    if (ar_idx == IDX_DECODER_STATUS)
      rd_value = dec_status & DEC_MASK;
    else if (ar_idx == IDX_SUBCODE_TIMER)
      rd_value = {6'h00, subt_status};
    else if (ar_idx == IDX_SCSI_EVENT)
      rd_value = scsi_status;
    else if (ar_idx == IDX_SCAM_EVENT)
      rd_value = {6'h00, scam_status};
    else if (ar_idx == IDX_DECODER_ENABLE)
      rd_value = dec_enable_r;
    else if (ar_idx == IDX_SUBTIM_ENABLE)
      rd_value = {6'h00, subt_enable_r};
    else if (ar_idx == IDX_SCSI_ENABLE)
      rd_value = scsi_enable_r;
    else if (ar_idx == IDX_SCAM_ENABLE)
      rd_value = {6'h00, scam_enable_r};
    else if (ar_idx == IDX_IRQ_SOURCE)
      rd_value = {5'h00, scsi_active | scam_active, subt_active,
                  dec_active};
    else if (ar_idx == IDX_SCSI_CONFIG)
      rd_value = config_r;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= {24'h000000, rd_value};
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // bus pins are asynchronous: two flops, then edge detect on the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_sync_r <= 2'h3;
      atn_sync_r <= 2'h3;
      rst_prev_r <= 1'b1;
      atn_prev_r <= 1'b1;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], bus_reset_line_n};
      atn_sync_r <= {atn_sync_r[0], attention_line_n};
      rst_prev_r <= rst_sync_r[1];
      atn_prev_r <= atn_sync_r[1];
    end
  end

  assign rst_edge = rst_prev_r && !rst_sync_r[1];
  assign atn_edge = atn_prev_r && !atn_sync_r[1] && target_mode;

  // retry counter; a limit of zero behaves as one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      retry_cnt_r <= '0;
    else if (reselect_start || resel_fail_set)
      retry_cnt_r <= '0;
    else if (reselect_attempt_failed)
      retry_cnt_r <= retry_cnt_r + 4'h1;
  end

  assign resel_fail_set = reselect_attempt_failed && !reselect_start &&
                          (retry_cnt_r + 4'h1 >= retry_limit);

  always_comb
  begin
    scsi_set = '0;
    scsi_set[BIT_COMMAND_DONE]     = command_done;
    scsi_set[BIT_COMMAND_REJECTED] = command_rejected;
    scsi_set[BIT_BUS_RESET_SEEN]   = rst_edge;
    scsi_set[BIT_ATTENTION_EVENT]  = atn_edge;
    scsi_set[BIT_BUS_PARITY_ERROR] = bus_parity_error &&
                                     parity_check_enable;
    scsi_set[BIT_SEL_ATTENTION]    = selected_with_attention;
    scsi_set[BIT_SEL_NO_ATTENTION] = selected_no_attention;
    scsi_set[BIT_RESELECT_FAILED]  = resel_fail_set;
    scam_set = '0;
    scam_set[BIT_SCAM_INIT_FAILED] = scam_init_failed;
    scam_set[BIT_SCAM_SELECTED]    = scam_selected;
  end

  irq_flag_group #(.W(DEC_W)) u_dec_group (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_in    (decoder_event_set & DEC_MASK),
    .clear_in  (dec_clear),
    .enable_in (dec_enable_r),
    .status    (dec_status),
    .active    (dec_active)
  );

  irq_flag_group #(.W(SUBT_W)) u_subt_group (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_in    (subcode_timer_set),
    .clear_in  (subt_clear),
    .enable_in (subt_enable_r),
    .status    (subt_status),
    .active    (subt_active)
  );

  // flags set with no reference to enables
  irq_flag_group #(.W(SCSI_W)) u_scsi_group (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_in    (scsi_set),
    .clear_in  (scsi_clear),
    .enable_in (scsi_enable_r),
    .status    (scsi_status),
    .active    (scsi_active)
  );

  irq_flag_group #(.W(SCAM_W)) u_scam_group (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set_in    (scam_set),
    .clear_in  (scam_clear),
    .enable_in (scam_enable_r),
    .status    (scam_status),
    .active    (scam_active)
  );

  assign irq = dec_active | subt_active | scsi_active | scam_active;

  a_irq_or_all: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (|(dec_status & dec_enable_r) || |(subt_status & subt_enable_r)
            || |(scsi_status & scsi_enable_r)
            || |(scam_status & scam_enable_r)))
    else $error("interrupt pin disagrees with flags");

  a_src_scsi_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && ar_idx == IDX_IRQ_SOURCE)
    |=> (s_axi_rdata[BIT_SRC_SCSI] == $past(scsi_active || scam_active))
        && (s_axi_rdata[BIT_SRC_DEC] == $past(dec_active)))
    else $error("source register wrong");

  a_clear_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (scsi_clear != '0) |=> (scsi_clear == '0))
    else $error("clear strobe held");

  a_rst_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(rst_sync_r[1]) ##1 1'b1 |=> scsi_status[BIT_BUS_RESET_SEEN])
    else $error("bus reset not flagged");

  a_parity_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    (bus_parity_error && !parity_check_enable) |->
      !scsi_set[BIT_BUS_PARITY_ERROR])
    else $error("parity flag set while checking off");

  a_resel_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    (reselect_attempt_failed && !reselect_start && retry_limit > 4'h1
     && retry_cnt_r == 4'h0) |=> !scsi_status[BIT_RESELECT_FAILED]
       || $past(scsi_status[BIT_RESELECT_FAILED]))
    else $error("reselect failure flagged too early");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
endmodule : host_interrupt_status_enable

// File: irq_regs_pkg.sv
// constants shared by the interrupt status and enable block
package irq_regs_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 8;
  localparam int IDX_LSB = 2;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DECODER_STATUS  = 8'h70;
  localparam logic [IDX_W-1:0] IDX_SUBCODE_TIMER   = 8'h71;
  localparam logic [IDX_W-1:0] IDX_SCSI_EVENT      = 8'h72;
  localparam logic [IDX_W-1:0] IDX_SCAM_EVENT      = 8'h73;
  localparam logic [IDX_W-1:0] IDX_DECODER_ENABLE  = 8'h74;
  localparam logic [IDX_W-1:0] IDX_SUBTIM_ENABLE   = 8'h75;
  localparam logic [IDX_W-1:0] IDX_SCSI_ENABLE     = 8'h76;
  localparam logic [IDX_W-1:0] IDX_SCAM_ENABLE     = 8'h77;
  localparam logic [IDX_W-1:0] IDX_IRQ_SOURCE      = 8'h78;
  localparam logic [IDX_W-1:0] IDX_SCSI_CONFIG     = 8'h80;

  // group widths
  localparam int DEC_W  = 8;
  localparam int SUBT_W = 2;
  localparam int SCSI_W = 8;
  localparam int SCAM_W = 2;

  // implemented bits of the decoder and subcode/timer groups
  localparam logic [DEC_W-1:0]  DEC_MASK  = 8'hfb;
  localparam logic [SUBT_W-1:0] SUBT_MASK = 2'h3;

  // scsi event bit positions
  localparam int BIT_COMMAND_DONE     = 7;
  localparam int BIT_COMMAND_REJECTED = 6;
  localparam int BIT_BUS_RESET_SEEN   = 5;
  localparam int BIT_ATTENTION_EVENT  = 4;
  localparam int BIT_BUS_PARITY_ERROR = 3;
  localparam int BIT_SEL_ATTENTION    = 2;
  localparam int BIT_SEL_NO_ATTENTION = 1;
  localparam int BIT_RESELECT_FAILED  = 0;
  // scam event bit positions
  localparam int BIT_SCAM_INIT_FAILED = 1;
  localparam int BIT_SCAM_SELECTED    = 0;

  // source register bit positions
  localparam int BIT_SRC_SCSI = 2;
  localparam int BIT_SRC_SUBT = 1;
  localparam int BIT_SRC_DEC  = 0;

  // configuration register fields
  localparam int BIT_PARITY_ENABLE = 0;
  localparam int RETRY_LSB         = 4;
  localparam int RETRY_W           = 4;

  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_regs_pkg

// File: irq_flag_group.sv
// one group of sticky event flags with write-one clear and enable gating
module irq_flag_group
  import irq_regs_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clear_in,
  input  wire logic [W-1:0] enable_in,
  output logic      [W-1:0] status,
  output logic              active
);
  logic [W-1:0] status_r;

  // set is or-ed after the clear so a coincident event survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= '0;
    else
      status_r <= (status_r & ~clear_in) | set_in;
  end

  assign status = status_r;
  // enables only gate active (the pin and the source register), never the flags
  assign active = |(status_r & enable_in);

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_in != '0) |=> ((status_r & $past(set_in)) == $past(set_in)))
    else $error("event flag lost");

  a_clear_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_in == '0) |=> (status_r == ($past(status_r) & ~$past(clear_in))))
    else $error("flag changed without event or clear");
endmodule : irq_flag_group

// File: irq_event_src.sv
// event source model standing in for the decoder and the scsi core
module irq_event_src
  import irq_regs_pkg::*;
(
  input  wire logic        aclk,
  output logic      [20:0] ev,
  output logic             rst_line_n,
  output logic             atn_line_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ev packs decoder[20:13], subcode/timer[12:11], scsi[10:3],
  // scam[2:1] and the reselect start pulse[0]
  initial
  begin
    ev = '0;
    rst_line_n = 1'b1;
    atn_line_n = 1'b1;
  end

  // every requested event fires for exactly one cycle
  task automatic pulse(input logic [20:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= '0;
  endtask : pulse

  // bus lines are pulled up, so release returns them high
  task automatic pin_low(input logic atn, input int n);
    @(posedge aclk);
    if (atn)
      atn_line_n <= 1'b0;
    else
      rst_line_n <= 1'b0;
    repeat (n) @(posedge aclk);
    atn_line_n <= 1'b1;
    rst_line_n <= 1'b1;
  endtask : pin_low
endmodule : irq_event_src

// File: tb_host_interrupt_status_enable.sv
// self-checking bench for the interrupt status and enable block
`define CHK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_host_interrupt_status_enable
  import irq_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [20:0]       ev;
  logic              rst_n;
  logic              atn_n;
  logic              target_mode;
  logic              parity_check_enable;
  logic              irq;
  int                miscompares;
  int                n_tests;

  irq_event_src src_u (.aclk(aclk), .ev(ev), .rst_line_n(rst_n),
                       .atn_line_n(atn_n));

  host_interrupt_status_enable dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .decoder_event_set(ev[20:13]), .subcode_timer_set(ev[12:11]),
    .command_done(ev[10]), .command_rejected(ev[9]),
    .bus_reset_line_n(rst_n), .attention_line_n(atn_n),
    .target_mode(target_mode), .bus_parity_error(ev[6]),
    .selected_with_attention(ev[5]), .selected_no_attention(ev[4]),
    .reselect_start(ev[0]), .reselect_attempt_failed(ev[3]),
    .scam_init_failed(ev[2]), .scam_selected(ev[1]),
    .parity_check_enable(parity_check_enable), .irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [20:0] evo(logic [7:0] d, logic [1:0] t,
                                      logic [7:0] s, logic [1:0] c);
    return {d, t, s, c, 1'b0};
  endfunction : evo

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex,
                    input logic [1:0] er, input string nm);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    `CHK(nm, {24'h0, ex}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd

  task automatic chk_irq(input logic ex);
    @(negedge aclk);
    `CHK("irq", ex, irq)
  endtask : chk_irq

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    miscompares = 0;
    n_tests = 0;
    aresetn = 1'b0;
    target_mode = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 'h70; i <= 'h78; i++)
      rd(i[7:0], ENABLE_RESET, RESP_OKAY, "reset");
    chk_irq(1'b0);
    $display("test reset done");
    wr(IDX_DECODER_ENABLE, 8'hff, RESP_OKAY);
    rd(IDX_DECODER_ENABLE, DEC_MASK, RESP_OKAY, "dec_en");
    wr(IDX_SUBTIM_ENABLE, 8'hff, RESP_OKAY);
    rd(IDX_SUBTIM_ENABLE, 8'h03, RESP_OKAY, "subt_en");
    wr(IDX_SCAM_ENABLE, 8'hff, RESP_OKAY);
    rd(IDX_SCAM_ENABLE, 8'h03, RESP_OKAY, "scam_en");
    wr(IDX_SCSI_ENABLE, 8'h5a, RESP_OKAY);
    rd(IDX_SCSI_ENABLE, 8'h5a, RESP_OKAY, "scsi_en");
    for (int i = 'h74; i <= 'h77; i++)
      wr(i[7:0], 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(IDX_DECODER_ENABLE, 8'hff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(IDX_DECODER_ENABLE, 8'h00, RESP_OKAY, "no_strobe");
    wr(8'h79, 8'h55, RESP_SLVERR);
    rd(8'h79, 8'h00, RESP_SLVERR, "unmapped");
    wr(IDX_IRQ_SOURCE, 8'hff, RESP_SLVERR);
    $display("test access done");
    src_u.pulse(evo(8'hff, 2'h0, 8'h00, 2'h0));
    rd(IDX_DECODER_STATUS, DEC_MASK, RESP_OKAY, "dec_st");
    chk_irq(1'b0);
    wr(IDX_DECODER_ENABLE, 8'h80, RESP_OKAY);
    chk_irq(1'b1);
    rd(IDX_IRQ_SOURCE, 8'h01, RESP_OKAY, "src_dec");
    rd(IDX_DECODER_STATUS, DEC_MASK, RESP_OKAY, "dec_kept");
    wr(IDX_DECODER_STATUS, 8'h81, RESP_OKAY);
    rd(IDX_DECODER_STATUS, 8'h7a, RESP_OKAY, "dec_clr");
    chk_irq(1'b0);
    wr(IDX_DECODER_STATUS, 8'hff, RESP_OKAY);
    wr(IDX_DECODER_ENABLE, 8'h00, RESP_OKAY);
    $display("test decoder done");
    src_u.pulse(evo(8'h00, 2'h3, 8'h00, 2'h0));
    wr(IDX_SUBTIM_ENABLE, 8'h01, RESP_OKAY);
    chk_irq(1'b1);
    rd(IDX_IRQ_SOURCE, 8'h02, RESP_OKAY, "src_subt");
    wr(IDX_SUBCODE_TIMER, 8'h01, RESP_OKAY);
    rd(IDX_SUBCODE_TIMER, 8'h02, RESP_OKAY, "subt_clr");
    chk_irq(1'b0);
    src_u.pulse(evo(8'h00, 2'h1, 8'h00, 2'h0));
    rd(IDX_SUBCODE_TIMER, 8'h03, RESP_OKAY, "subt_reset");
    wr(IDX_SUBCODE_TIMER, 8'h03, RESP_OKAY);
    wr(IDX_SUBTIM_ENABLE, 8'h00, RESP_OKAY);
    $display("test subcode done");
    src_u.pulse(evo(8'h00, 2'h0, 8'hce, 2'h0));
    src_u.pin_low(1'b1, 6);
    rd(IDX_SCSI_EVENT, 8'hc6, RESP_OKAY, "scsi_noparity");
    wr(IDX_SCSI_CONFIG, 8'h01, RESP_OKAY);
    `CHK("par_en", 1'b1, parity_check_enable)
    src_u.pulse(evo(8'h00, 2'h0, 8'h08, 2'h0));
    rd(IDX_SCSI_EVENT, 8'hce, RESP_OKAY, "scsi_parity");
    src_u.pin_low(1'b0, 6);
    rd(IDX_SCSI_EVENT, 8'hee, RESP_OKAY, "scsi_rst");
    target_mode <= 1'b1;
    src_u.pin_low(1'b1, 6);
    rd(IDX_SCSI_EVENT, 8'hfe, RESP_OKAY, "scsi_atn");
    chk_irq(1'b0);
    wr(IDX_SCSI_ENABLE, 8'h10, RESP_OKAY);
    chk_irq(1'b1);
    rd(IDX_IRQ_SOURCE, 8'h04, RESP_OKAY, "src_scsi");
    wr(IDX_SCSI_EVENT, 8'h0f, RESP_OKAY);
    rd(IDX_SCSI_EVENT, 8'hf0, RESP_OKAY, "scsi_clr");
    wr(IDX_SCSI_EVENT, 8'hff, RESP_OKAY);
    chk_irq(1'b0);
    wr(IDX_SCSI_ENABLE, 8'h00, RESP_OKAY);
    $display("test scsi done");
    wr(IDX_SCSI_CONFIG, 8'h31, RESP_OKAY);
    src_u.pulse(21'h000001);
    for (int i = 0; i < 3; i++)
    begin
      rd(IDX_SCSI_EVENT, 8'h00, RESP_OKAY, "resel_wait");
      src_u.pulse(evo(8'h00, 2'h0, 8'h01, 2'h0));
    end
    rd(IDX_SCSI_EVENT, 8'h01, RESP_OKAY, "resel_fail");
    wr(IDX_SCSI_EVENT, 8'h01, RESP_OKAY);
    fork
      wr(IDX_SCSI_EVENT, 8'h80, RESP_OKAY);
      begin
        @(posedge aclk);
        src_u.pulse(evo(8'h00, 2'h0, 8'h80, 2'h0));
      end
    join
    rd(IDX_SCSI_EVENT, 8'h80, RESP_OKAY, "set_wins");
    wr(IDX_SCSI_EVENT, 8'h80, RESP_OKAY);
    $display("test reselect done");
    src_u.pulse(evo(8'h00, 2'h0, 8'h00, 2'h3));
    rd(IDX_SCAM_EVENT, 8'h03, RESP_OKAY, "scam_st");
    wr(IDX_SCAM_ENABLE, 8'h02, RESP_OKAY);
    chk_irq(1'b1);
    rd(IDX_IRQ_SOURCE, 8'h04, RESP_OKAY, "src_scam");
    wr(IDX_SCAM_EVENT, 8'h02, RESP_OKAY);
    rd(IDX_SCAM_EVENT, 8'h01, RESP_OKAY, "scam_clr");
    chk_irq(1'b0);
    wr(IDX_SCAM_EVENT, 8'h01, RESP_OKAY);
    rd(IDX_SCAM_EVENT, 8'h00, RESP_OKAY, "scam_clr0");
    $display("test scam done");
    finish_test();
  end
endmodule : tb_host_interrupt_status_enable
